// ==== core/ebt_pkg.sv ====
/*
 * shared constants and types of the eight bit timer with capture:
 * register offsets, field positions, reset values, divider counts.
 * assumes a 32-bit apb master with byte addresses on an 8-bit bus.
 */
package ebt_pkg;

	// ********************************************************
	// register map
	// ********************************************************
	localparam logic [7:0] EBT_OFS_CTRL_TWO = 8'h00;
	localparam logic [7:0] EBT_OFS_CTRL_ONE = 8'h04;
	localparam logic [7:0] EBT_OFS_STATUS = 8'h08;
	localparam logic [7:0] EBT_OFS_CAP_ONE = 8'h0C;
	localparam logic [7:0] EBT_OFS_COUNTER = 8'h10;
	localparam logic [7:0] EBT_OFS_ALT_COUNTER = 8'h14;
	localparam logic [7:0] EBT_OFS_CAP_TWO = 8'h18;
	localparam logic [7:0] EBT_OFS_IRQ_MASK = 8'h1C;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int EBT_CR2_CLKSEL_HI = 3;
	localparam int EBT_CR2_CLKSEL_LO = 2;
	localparam int EBT_CR2_EDGE_TWO = 1;
	localparam int EBT_CR1_CAP_IRQ_EN = 7;
	localparam int EBT_CR1_OVF_IRQ_EN = 5;
	localparam int EBT_CR1_EDGE_ONE = 1;
	localparam int EBT_SR_CAP_ONE = 7;
	localparam int EBT_SR_OVF = 5;
	localparam int EBT_SR_CAP_TWO = 4;

	// ********************************************************
	// reset values and counts
	// ********************************************************
	localparam logic [7:0] EBT_CTRL_RESET = 8'h00;
	localparam logic [7:0] EBT_MASK_RESET = 8'h00;
	localparam logic [7:0] EBT_COUNT_RELOAD = 8'hFC;
	localparam logic [7:0] EBT_COUNT_TOP = 8'hFF;
	localparam logic [1:0] EBT_CLKSEL_DIV4 = 2'h0;
	localparam logic [1:0] EBT_CLKSEL_DIV2 = 2'h1;
	localparam logic [1:0] EBT_CLKSEL_DIV8 = 2'h2;
	localparam logic [1:0] EBT_CLKSEL_OSC = 2'h3;
	localparam logic [2:0] EBT_DIV2_LAST = 3'h1;
	localparam logic [2:0] EBT_DIV4_LAST = 3'h3;
	localparam logic [2:0] EBT_DIV8_LAST = 3'h7;
	localparam int EBT_OSC_DIVIDE = 8000;

	// ********************************************************
	// carriers
	// ********************************************************
	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} ebt_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ebt_apb_rsp_type;

	typedef struct packed {
		logic sync_a;
		logic sync_b;
		logic prev;
	} ebt_edge_state_type;

endpackage

// ==== core/ebt_edge_detect.sv ====
/*
 * two flop synchroniser with selectable edge detection.
 * assumes the pin changes no faster than every two clock cycles.
 */
`timescale 1ns/1ps
module ebt_edge_detect
	import ebt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// pin side
	input wire logic pin_in,
	input wire logic rising_in,
	// event
	output logic event_out
);

	ebt_edge_state_type st_q;
	ebt_edge_state_type st_d;

	always_comb begin
		st_d = st_q;
		st_d.sync_a = pin_in;
		st_d.sync_b = st_q.sync_a;
		st_d.prev = st_q.sync_b;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			st_q <= '{sync_a: 1'b1, sync_b: 1'b1, prev: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	// edge select: 1 rising, 0 falling
	assign event_out = rising_in ? (st_q.sync_b & ~st_q.prev) :
		(~st_q.sync_b & st_q.prev);

endmodule

// ==== core/ebt_timer.sv ====
/*
 * eight bit free running timer with prescaler, overflow flag and two
 * input capture channels, reached over apb.
 * assumes capture pins and the oscillator clock are asynchronous and
 * slower than half the cpu clock; the cpu supplies its interrupt mask
 * and halt level.
 */
`timescale 1ns/1ps
module ebt_timer
	import ebt_pkg::*;
#(
	parameter bit CAP_ONE_BONDED = 1'b1,
	parameter bit CAP_TWO_BONDED = 1'b1,
	parameter int OSC_DIVIDE = EBT_OSC_DIVIDE
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// apb slave
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// pins and cpu state
	input wire logic capture_pin_one_in,
	input wire logic capture_pin_two_in,
	input wire logic secondary_osc_clock_in,
	input wire logic cpu_irq_mask_in,
	input wire logic cpu_halt_in,
	// interrupt
	output logic irq_out
);

	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic [7:0] control_reg_two;
		logic [7:0] control_reg_one;
		logic [7:0] irq_mask;
		logic overflow_flag;
		logic cap_one_flag;
		logic cap_two_flag;
		logic ovf_armed;
		logic cap_one_armed;
		logic cap_two_armed;
		logic [7:0] count;
		logic [7:0] cap_one_value;
		logic [7:0] cap_two_value;
		logic [2:0] presc;
		logic [13:0] osc_count;
		logic ack;
		logic [31:0] prdata;
		logic slverr;
	} ebt_state_type;

	ebt_state_type st_q;
	ebt_state_type st_d;
	ebt_apb_req_type req;

	logic cap_one_evt;
	logic cap_two_evt;
	logic osc_edge;
	logic pin_one;
	logic pin_two;

	assign req = '{paddr: paddr_in, psel: psel_in, penable: penable_in,
		pwrite: pwrite_in, pwdata: pwdata_in};

	// ********************************************************
	// pin conditioning
	// ********************************************************
	// an unbonded pin is tied high, so it can never make an edge
	assign pin_one = CAP_ONE_BONDED ? capture_pin_one_in : 1'b1;
	assign pin_two = CAP_TWO_BONDED ? capture_pin_two_in : 1'b1;

	ebt_edge_detect u_cap_one (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.pin_in(pin_one),
		.rising_in(st_q.control_reg_one[EBT_CR1_EDGE_ONE]),
		.event_out(cap_one_evt)
	);

	ebt_edge_detect u_cap_two (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.pin_in(pin_two),
		.rising_in(st_q.control_reg_two[EBT_CR2_EDGE_TWO]),
		.event_out(cap_two_evt)
	);

	ebt_edge_detect u_osc (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.pin_in(secondary_osc_clock_in),
		.rising_in(1'b1),
		.event_out(osc_edge)
	);

	// ********************************************************
	// next state
	// ********************************************************
	always_comb begin
		logic access;
		logic done;
		logic wr;
		logic rd;
		logic tick;
		logic [2:0] last;
		logic [1:0] csel;
		logic hit_cnt;
		logic hit_alt;
		logic hit_sr;
		logic hit_c1;
		logic hit_c2;
		logic mapped;
		logic [7:0] rdval;
		logic [7:0] sr_val;
		logic [7:0] wbyte;
		access = 1'b0;
		done = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		tick = 1'b0;
		last = EBT_DIV4_LAST;
		csel = 2'h0;
		hit_cnt = 1'b0;
		hit_alt = 1'b0;
		hit_sr = 1'b0;
		hit_c1 = 1'b0;
		hit_c2 = 1'b0;
		mapped = 1'b1;
		rdval = 8'h00;
		sr_val = 8'h00;
		wbyte = 8'h00;
		st_d = st_q;

		// ********************************************************
		// apb decode
		// ********************************************************
		access = req.psel & req.penable;
		done = access & st_q.ack;
		wr = done & req.pwrite;
		rd = done & ~req.pwrite;
		wbyte = req.pwdata[7:0];
		hit_cnt = req.paddr == EBT_OFS_COUNTER;
		hit_alt = req.paddr == EBT_OFS_ALT_COUNTER;
		hit_sr = req.paddr == EBT_OFS_STATUS;
		hit_c1 = req.paddr == EBT_OFS_CAP_ONE;
		hit_c2 = req.paddr == EBT_OFS_CAP_TWO;

		// ********************************************************
		// status view
		// ********************************************************
		sr_val[EBT_SR_CAP_ONE] = st_q.cap_one_flag;
		sr_val[EBT_SR_OVF] = st_q.overflow_flag;
		sr_val[EBT_SR_CAP_TWO] = st_q.cap_two_flag;

		// ********************************************************
		// apb answer and read mux
		// ********************************************************
		// one wait state; read data is loaded in the first access cycle
		st_d.ack = access & ~st_q.ack;
		unique case (req.paddr)
			EBT_OFS_CTRL_TWO: rdval = st_q.control_reg_two;
			EBT_OFS_CTRL_ONE: rdval = st_q.control_reg_one;
			EBT_OFS_STATUS: rdval = sr_val;
			EBT_OFS_CAP_ONE: rdval = st_q.cap_one_value;
			EBT_OFS_COUNTER: rdval = st_q.count;
			EBT_OFS_ALT_COUNTER: rdval = st_q.count;
			EBT_OFS_CAP_TWO: rdval = st_q.cap_two_value;
			EBT_OFS_IRQ_MASK: rdval = st_q.irq_mask;
			default: mapped = 1'b0;
		endcase
		if (access & ~st_q.ack) begin
			st_d.prdata = {24'h00_0000, rdval};
			st_d.slverr = ~mapped;
		end

		// ********************************************************
		// control writes
		// ********************************************************
		if (wr && req.paddr == EBT_OFS_CTRL_TWO) begin
			st_d.control_reg_two = wbyte;
		end
		if (wr && req.paddr == EBT_OFS_CTRL_ONE) begin
			st_d.control_reg_one = wbyte;
		end
		if (wr && req.paddr == EBT_OFS_IRQ_MASK) begin
			st_d.irq_mask = wbyte;
		end

		// ********************************************************
		// prescaler
		// ********************************************************
		// frozen in halt; wait has no effect
		// the oscillator is counted by its synchronised rising edges
		csel = st_q.control_reg_two[EBT_CR2_CLKSEL_HI:EBT_CR2_CLKSEL_LO];
		unique case (csel)
			EBT_CLKSEL_DIV4: last = EBT_DIV4_LAST;
			EBT_CLKSEL_DIV2: last = EBT_DIV2_LAST;
			EBT_CLKSEL_DIV8: last = EBT_DIV8_LAST;
			EBT_CLKSEL_OSC: last = EBT_DIV8_LAST;
		endcase
		if (!cpu_halt_in) begin
			if (csel == EBT_CLKSEL_OSC) begin
				if (osc_edge) begin
					if (st_q.osc_count >= 14'(OSC_DIVIDE - 1)) begin
						st_d.osc_count = 14'h0000;
						tick = 1'b1;
					end else begin
						st_d.osc_count = st_q.osc_count + 14'h0001;
					end
				end
			end else begin
				if (st_q.presc >= last) begin
					st_d.presc = 3'h0;
					tick = 1'b1;
				end else begin
					st_d.presc = st_q.presc + 3'h1;
				end
			end
		end

		// ********************************************************
		// counter
		// ********************************************************
		// a counter write wins over a tick in the same cycle
		if (tick) begin
			st_d.count = st_q.count + 8'h01;
		end
		if (wr && (hit_cnt || hit_alt)) begin
			st_d.count = EBT_COUNT_RELOAD;
		end

		// ********************************************************
		// flag clearing
		// ********************************************************
		// two step clear: status read arms flags that are set
		if (rd && hit_sr) begin
			st_d.ovf_armed = st_q.overflow_flag;
			st_d.cap_one_armed = st_q.cap_one_flag;
			st_d.cap_two_armed = st_q.cap_two_flag;
		end
		if (done && hit_cnt && st_q.ovf_armed) begin
			st_d.overflow_flag = 1'b0;
			st_d.ovf_armed = 1'b0;
		end
		if (done && hit_c1 && st_q.cap_one_armed) begin
			st_d.cap_one_flag = 1'b0;
			st_d.cap_one_armed = 1'b0;
		end
		if (done && hit_c2 && st_q.cap_two_armed) begin
			st_d.cap_two_flag = 1'b0;
			st_d.cap_two_armed = 1'b0;
		end
		// write one to status also clears
		if (wr && hit_sr) begin
			if (wbyte[EBT_SR_OVF]) begin
				st_d.overflow_flag = 1'b0;
			end
			if (wbyte[EBT_SR_CAP_ONE]) begin
				st_d.cap_one_flag = 1'b0;
			end
			if (wbyte[EBT_SR_CAP_TWO]) begin
				st_d.cap_two_flag = 1'b0;
			end
		end

		// ********************************************************
		// flag setting
		// ********************************************************
		// events set last, so a set beats a same cycle clear
		if (tick && st_q.count == EBT_COUNT_TOP) begin
			st_d.overflow_flag = 1'b1;
		end
		if (cap_one_evt) begin
			st_d.cap_one_value = st_q.count;
			st_d.cap_one_flag = 1'b1;
		end
		if (cap_two_evt) begin
			st_d.cap_two_value = st_q.count;
			st_d.cap_two_flag = 1'b1;
		end
	end

	// ********************************************************
	// registers
	// ********************************************************
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			st_q <= '0;
			st_q.control_reg_two <= EBT_CTRL_RESET;
			st_q.control_reg_one <= EBT_CTRL_RESET;
			st_q.irq_mask <= EBT_MASK_RESET;
			st_q.count <= EBT_COUNT_RELOAD;
		end else begin
			st_q <= st_d;
		end
	end

	// ********************************************************
	// outputs
	// ********************************************************
	assign prdata_out = st_q.prdata;
	// ready waits for the ack flop, so every transfer has one wait state
	assign pready_out = psel_in & penable_in & st_q.ack;
	assign pslverr_out = psel_in & penable_in & st_q.ack & st_q.slverr;

	// pending flags request only while the cpu mask is clear
	// overflow and both captures share the one request line
	assign irq_out = ~cpu_irq_mask_in & (
		(st_q.overflow_flag & st_q.irq_mask[EBT_SR_OVF] &
		st_q.control_reg_one[EBT_CR1_OVF_IRQ_EN]) |
		((st_q.cap_one_flag & st_q.irq_mask[EBT_SR_CAP_ONE]) |
		(st_q.cap_two_flag & st_q.irq_mask[EBT_SR_CAP_TWO])) &
		st_q.control_reg_one[EBT_CR1_CAP_IRQ_EN]);

endmodule

// ==== bench/ebt_timer_checker.sv ====
/* port checks of the eight bit timer with capture.
 * assumes it is bound to each timer instance. */
`timescale 1ns/1ps
module ebt_timer_checker
	import ebt_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// apb
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// cpu and interrupt
	input wire logic cpu_irq_mask_in,
	input wire logic irq_out
);
	// *****
	// properties
	// *****
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	property p_mask;
		cpu_irq_mask_in |-> !irq_out;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
	property p_rst;
		$rose(resetn_in) |-> !irq_out && !pready_out;
	endproperty
	a_rst: assert property (p_rst) else $error("state after reset");
	property p_ans;
		psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out;
	endproperty
	a_ans: assert property (p_ans) else $error("answer timing");
	property p_one;
		pready_out |=> !pready_out;
	endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_err;
		pready_out && paddr_in > EBT_OFS_IRQ_MASK |-> pslverr_out;
	endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_errq;
		pslverr_out |-> pready_out;
	endproperty
	a_errq: assert property (p_errq) else $error("stray error");
	property p_hi;
		pready_out |-> prdata_out[31:8] == 24'h00_0000;
	endproperty
	a_hi: assert property (p_hi) else $error("upper data");
	property p_hold;
		irq_out && !pready_out ##1 !cpu_irq_mask_in |-> irq_out;
	endproperty
	a_hold: assert property (p_hold) else $error("irq dropped");
	c_irq: cover property (irq_out);
	c_err: cover property (pslverr_out);
	c_sr: cover property (pready_out && paddr_in == EBT_OFS_STATUS);
endmodule
bind ebt_timer ebt_timer_checker ebt_timer_checker_inst (.ref_clk_in,
	.resetn_in, .paddr_in, .psel_in, .penable_in, .prdata_out,
	.pready_out, .pslverr_out, .cpu_irq_mask_in, .irq_out);

// ==== bench/ebt_pin_model.sv ====
/* model of the two capture pin drivers.
 * assumes requests change no faster than every two cycles. */
`timescale 1ns/1ps
module ebt_pin_model (
	// clock
	input wire logic ref_clk_in,
	// requested levels
	input wire logic [1:0] level_in,
	// pins
	output logic pin_one_out,
	output logic pin_two_out
);
	initial {pin_two_out, pin_one_out} = 2'b11;
	// pins idle high and follow a request one cycle later
	always @(posedge ref_clk_in) begin
		{pin_two_out, pin_one_out} <= level_in;
	end
endmodule

// ==== bench/ebt_timer_tb_top.sv ====
/* self-checking bench of the eight bit timer with capture.
 * assumes the checker is bound and the pin model drives the pins. */
`timescale 1ns/1ps
module ebt_timer_tb_top
	import ebt_pkg::*;
;
	logic ref_clk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, osc = 1'b0, cpu_mask = 1'b1, halt = 1'b1;
	logic pready, pslverr, irq, pin1, pin2, err, e;
	logic [1:0] lvl = 2'b11;
	logic [7:0] paddr = 8'h00, v, cnt_e;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [7:0] ra[6] = '{EBT_OFS_CTRL_TWO, EBT_OFS_CTRL_ONE, EBT_OFS_STATUS,
		EBT_OFS_COUNTER, EBT_OFS_ALT_COUNTER, EBT_OFS_IRQ_MASK};
	logic [7:0] re[6] = '{8'h00, 8'h00, 8'h00, 8'hFC, 8'hFC, 8'h00};
	int failures = 0, num_checks = 0, cyc = 0, k, ch;
	int dv[3] = '{4, 2, 8};
	ebt_timer #(.OSC_DIVIDE(4)) ebt_timer_inst (.ref_clk_in, .resetn_in,
		.paddr_in(paddr), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.capture_pin_one_in(pin1), .capture_pin_two_in(pin2),
		.secondary_osc_clock_in(osc), .cpu_irq_mask_in(cpu_mask),
		.cpu_halt_in(halt), .irq_out(irq));
	ebt_pin_model ebt_pin_model_inst (.ref_clk_in, .level_in(lvl),
		.pin_one_out(pin1), .pin_two_out(pin2));
	// *****
	// clock, oscillator and timeout
	// *****
	always #4 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3)
			osc <= ~osc;
		if (cyc == 20000) begin
			failures = failures + 1;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] x, y);
		num_checks++;
		if (y !== x) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, x, y);
		end
	endtask
	function automatic logic [7:0] flags(input logic c1, o, c2);
		return {c1, 1'b0, o, c2, 4'h0};
	endfunction
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge ref_clk_in);
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		psel <= 1'b1;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		@(posedge ref_clk_in);
		while (pready !== 1'b1)
			@(posedge ref_clk_in);
		v = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 8'h00);
	endtask
	task automatic run(input int n);
		halt <= 1'b0;
		repeat (n) @(posedge ref_clk_in);
		halt <= 1'b1;
	endtask
	task automatic pin(input logic l);
		lvl[ch] <= l;
		repeat (6) @(posedge ref_clk_in);
	endtask
	// *****
	// tests
	// *****
	initial begin
		k = $urandom(32'h775a_e732);
		repeat (5) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk("reset value", re[i], v);
		end
		apb(8'h20, 1'b1, 8'hFF);
		chk("unmapped", 8'h01, {7'h00, err});
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			k = $urandom_range(8, 1);
			apb(EBT_OFS_CTRL_TWO, 1'b1, {4'h0, i[1:0], 2'b00});
			apb(EBT_OFS_STATUS, 1'b1, 8'hFF);
			apb(EBT_OFS_COUNTER, 1'b1, 8'h5A);
			run(k * dv[i]);
			rd(EBT_OFS_ALT_COUNTER);
			chk("count", 8'hFC + k[7:0], v);
			rd(EBT_OFS_STATUS);
			chk("status", flags(1'b0, k > 3, 1'b0), v);
		end
		apb(EBT_OFS_CTRL_TWO, 1'b1, 8'h0C);
		apb(EBT_OFS_ALT_COUNTER, 1'b1, 8'h00);
		run(320);
		rd(EBT_OFS_ALT_COUNTER);
		cnt_e = v - 8'hFC;
		chk("osc ticks", 8'h01, {7'h00, cnt_e inside {[9:11]}});
		$display("test prescaler done");
		apb(EBT_OFS_CTRL_TWO, 1'b1, 8'h04);
		apb(EBT_OFS_STATUS, 1'b1, 8'hFF);
		apb(EBT_OFS_COUNTER, 1'b1, 8'h00);
		run(8);
		apb(EBT_OFS_IRQ_MASK, 1'b1, 8'hB0);
		apb(EBT_OFS_CTRL_ONE, 1'b1, 8'h20);
		chk("masked irq", 8'h00, {7'h00, irq});
		cpu_mask <= 1'b0;
		@(posedge ref_clk_in);
		chk("irq", 8'h01, {7'h00, irq});
		rd(EBT_OFS_STATUS);
		rd(EBT_OFS_ALT_COUNTER);
		rd(EBT_OFS_STATUS);
		chk("overflow kept", flags(1'b0, 1'b1, 1'b0), v);
		rd(EBT_OFS_COUNTER);
		rd(EBT_OFS_STATUS);
		chk("overflow cleared", 8'h00, v);
		chk("irq cleared", 8'h00, {7'h00, irq});
		$display("test overflow done");
		for (int i = 0; i < 4; i++) begin
			ch = i % 2;
			e = i[1];
			apb(EBT_OFS_CTRL_ONE, 1'b1, {6'h20, e ^ ch[0], 1'b0});
			apb(EBT_OFS_CTRL_TWO, 1'b1, {6'h01, ~(e ^ ch[0]), 1'b0});
			apb(EBT_OFS_COUNTER, 1'b1, 8'h00);
			run(2 * i + 2);
			cnt_e = 8'hFC + i[7:0] + 8'h01;
			pin(~e);
			apb(EBT_OFS_STATUS, 1'b1, 8'hFF);
			pin(e);
			rd(EBT_OFS_STATUS);
			chk("flag", flags(ch == 0, 1'b0, ch == 1), v);
			chk("capture irq", 8'h01, {7'h00, irq});
			rd(ch ? EBT_OFS_CAP_TWO : EBT_OFS_CAP_ONE);
			chk("capture value", cnt_e, v);
			pin(~e);
			rd(EBT_OFS_STATUS);
			chk("flag cleared", 8'h00, v);
		end
		$display("test capture done");
		end_sim();
	end
endmodule
